/* File: tw_consts.vh */
`ifndef TW_CONSTS_VH
`define TW_CONSTS_VH
// --------------------------------------------------------------
// Register indexes on the plain register port
// --------------------------------------------------------------
`define TW_REG_CON1 3'h0
`define TW_REG_CON2 3'h1
`define TW_REG_STAT 3'h2
`define TW_REG_BUF 3'h3
`define TW_REG_ADDR 3'h4
`define TW_REG_IFLAG 3'h5
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define TW_C1_WRITE_COLLISION_FLAG 7
`define TW_C1_OV 6
`define TW_C1_EN 5
`define TW_C1_CKP 4
`define TW_C2_GENERAL_CALL_ENABLE 7
`define TW_C2_ACKSTAT 6
`define TW_C2_ACKDT 5
`define TW_C2_RCEN 3
`define TW_C2_PEN 2
`define TW_C2_SEN 0
`define TW_ST_BF 0
`define TW_ST_UA 1
`define TW_ST_RW 2
`define TW_IF_BIT 0
// --------------------------------------------------------------
// Mode codes and fixed values
// --------------------------------------------------------------
`define TW_M_SL7 4'h6
`define TW_M_SL10 4'h7
`define TW_M_MST 4'h8
`define TW_M_FWM 4'hB
`define TW_M_SL7SP 4'hE
`define TW_M_SL10SP 4'hF
`define TW_RST_BYTE 8'h00
`define TW_GC_ADDR 8'h00
// --------------------------------------------------------------
// Timing: reload value = fosc / (4 * fscl) - 1
// --------------------------------------------------------------
`define TW_FOSC_HZ 25000000
`define TW_SCL_100K_HZ 100000
`define TW_SCL_400K_HZ 400000
`define TW_SCL_1M_HZ 1000000
`define TW_BRG_100K ((`TW_FOSC_HZ / (4 * `TW_SCL_100K_HZ)) - 1)
`define TW_BRG_400K ((`TW_FOSC_HZ / (4 * `TW_SCL_400K_HZ)) - 1)
`define TW_BRG_1M ((`TW_FOSC_HZ / (4 * `TW_SCL_1M_HZ)) - 1)
`endif

/* File: tw_sync.v */
`timescale 1ns/1ns
// --------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// --------------------------------------------------------------
module tw_sync #(
  parameter WIDTH = 2
) (
  input wire clk,
  input wire reset_n,
  input wire [WIDTH-1:0] pinIn,
  output reg [WIDTH-1:0] pinOut
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  genvar i;

  // Idle bus level is high, so reset to ones to avoid a false start
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= {WIDTH{1'b1}};
      s2_q <= {WIDTH{1'b1}};
      s3_q <= {WIDTH{1'b1}};
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gFilt
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          pinOut[i] <= 1'b1;
        end else if (s2_q[i] == s3_q[i]) begin
          pinOut[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule

/* File: tw_serial_port.v */
// Summary of operation
// [RL1] Master: buffer write while busy sets collision
// [RL2] Slave transmit: write while shifting sets collision
// [RL3] Receive into full buffer sets overflow
// [RL4] Enable bit hands pins to port
// [RL5] Slave holds clock low while release bit 0
// [RL6] Codes 0110/0111 select 7/10-bit slave
// [RL7] Code 1000 master, clock fosc/(4*(reload+1))
// [RL8] Codes 1110/1111 slave plus start/stop interrupt
// [RL9] Code 1011 firmware master, slave idle
// [RL10] All-zero address byte is general call
// [RL11] General call needs general call enable
// [RL12] Slave shifts 8 bits, compares both addresses
// [RL13] Match loads buffer, flag on ninth fall
// [RL14] 10-bit match sets update address flag
// [RL15] General call in 10-bit skips second half
// [RL16] Master makes clocks, start, stop; restart holds bus
// [RL17] Transmit address ends write bit 0
// [RL18] Receive: master acknowledges each byte
// [RL19] Reload divider reaches 100k, 400k, 1M
// [RL20] Start trigger, start, then interrupt flag
// [RL21] Master stores slave acknowledge in status
// [RL22] Flag at end of ninth clock
// [RL23] Stop trigger, flag once stop completes
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "tw_consts.vh"
module tw_serial_port (
  input wire clk,
  input wire reset_n,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire sclIn,
  output reg sclOut,
  output reg sclOe,
  output reg pinsOwned
);
  localparam M_IDLE = 3'd0;
  localparam M_START = 3'd1;
  localparam M_XFER = 3'd2;
  localparam M_ACK = 3'd3;
  localparam M_STOP = 3'd4;
  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_ADDR2 = 3'd2;
  localparam S_RX = 3'd3;
  localparam S_TX = 3'd4;

  // --------------------------------------------------------------
  // Software visible state
  // --------------------------------------------------------------
  reg write_collision_flag_q, ov_q, en_q, ckp_q;
  reg [3:0] mode_q;
  reg general_call_enable_q, ackStat_q, ackDt_q, rcen_q, pen_q, sen_q;
  reg bf_q, ua_q, rw_q, intFlag_q;
  reg [7:0] buf_q, add_q;
  // Master sequencer
  reg [2:0] mSt_q;
  reg [1:0] mPh_q;
  reg [2:0] mBit_q;
  reg [7:0] mSr_q;
  reg mRx_q, mSdaLow_q, mSclLow_q;
  reg [7:0] brg_q;
  // Slave engine
  reg [2:0] sSt_q;
  reg [3:0] sCnt_q;
  reg [7:0] sSr_q, sTx_q;
  reg sAckPend_q, sInAck_q, sSdaLow_q, sSclLow_q;
  reg sclP_q, sdaP_q;
  wire [1:0] pinsS;
  wire sclS = pinsS[1];
  wire sdaS = pinsS[0];

  tw_sync #(.WIDTH(2)) uSync (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn({sclIn, sdaIn}),
    .pinOut(pinsS)
  );

  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  wire isMst = (mode_q == `TW_M_MST) | (mode_q == `TW_M_FWM); // RL7 RL9
  wire is10 = (mode_q == `TW_M_SL10) | (mode_q == `TW_M_SL10SP); // RL6
  wire ssIrq = (mode_q == `TW_M_SL7SP) | (mode_q == `TW_M_SL10SP); // RL8
  wire isSl = en_q & (is10 | ssIrq | (mode_q == `TW_M_SL7)); // RL6 RL9
  wire wrBuf = regWr & (regAddr == `TW_REG_BUF);
  wire rise = sclS & ~sclP_q;
  wire fall = ~sclS & sclP_q;
  wire startDet = sclS & sclP_q & sdaP_q & ~sdaS;
  wire stopDet = sclS & sclP_q & ~sdaP_q & sdaS;
  wire [7:0] newByte = {sSr_q[6:0], sdaS};
  wire byteDone = isSl & rise & (sSt_q != S_IDLE) & (sCnt_q == 4'h7);
  wire gcHit = general_call_enable_q & (newByte == `TW_GC_ADDR); // RL10 RL11
  wire adHit = newByte[7:1] == add_q[7:1];
  wire mBusy = (mSt_q != M_IDLE) | sen_q | pen_q | rcen_q;
  // Quarter-bit tick; reload of N gives fosc / (4 * (N + 1)) on the line
  wire tick = (brg_q == 8'h00); // RL7 RL19
  // Master waits in the high phase while someone stretches the clock
  wire mGo = en_q & isMst & tick & ~((mPh_q == 2'd2) & ~sclS);
  wire [2:0] txIdx = 3'd7 - sCnt_q[2:0];

  // --------------------------------------------------------------
  // Reload divider, runs only while the master sequencer is busy
  // --------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      brg_q <= `TW_RST_BYTE;
    end else if (tick | ~mBusy) begin
      brg_q <= add_q; // RL7 RL19
    end else begin
      brg_q <= brg_q - 8'h01;
    end
  end

  // --------------------------------------------------------------
  // Registers, master and slave engines
  // --------------------------------------------------------------
  // Software writes come first so that hardware sets later win
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      write_collision_flag_q <= 1'b0;
      ov_q <= 1'b0;
      en_q <= 1'b0;
      ckp_q <= 1'b0;
      mode_q <= 4'h0;
      general_call_enable_q <= 1'b0;
      ackStat_q <= 1'b0;
      ackDt_q <= 1'b0;
      rcen_q <= 1'b0;
      pen_q <= 1'b0;
      sen_q <= 1'b0;
      bf_q <= 1'b0;
      ua_q <= 1'b0;
      rw_q <= 1'b0;
      intFlag_q <= 1'b0;
      buf_q <= `TW_RST_BYTE;
      add_q <= `TW_RST_BYTE;
      mSt_q <= M_IDLE;
      mPh_q <= 2'd0;
      mBit_q <= 3'd0;
      mSr_q <= `TW_RST_BYTE;
      mRx_q <= 1'b0;
      mSdaLow_q <= 1'b0;
      mSclLow_q <= 1'b0;
      sSt_q <= S_IDLE;
      sCnt_q <= 4'h0;
      sSr_q <= `TW_RST_BYTE;
      sTx_q <= `TW_RST_BYTE;
      sAckPend_q <= 1'b0;
      sInAck_q <= 1'b0;
      sSdaLow_q <= 1'b0;
      sSclLow_q <= 1'b0;
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
      // Software side
      if (regWr) begin
        case (regAddr)
          `TW_REG_CON1: begin
            write_collision_flag_q <= regWdata[`TW_C1_WRITE_COLLISION_FLAG];
            ov_q <= regWdata[`TW_C1_OV];
            en_q <= regWdata[`TW_C1_EN];
            ckp_q <= regWdata[`TW_C1_CKP];
            mode_q <= regWdata[3:0];
          end
          `TW_REG_CON2: begin
            general_call_enable_q <= regWdata[`TW_C2_GENERAL_CALL_ENABLE];
            ackDt_q <= regWdata[`TW_C2_ACKDT];
            rcen_q <= rcen_q | regWdata[`TW_C2_RCEN];
            pen_q <= pen_q | regWdata[`TW_C2_PEN];
            sen_q <= sen_q | regWdata[`TW_C2_SEN]; // RL20 RL23
          end
          `TW_REG_ADDR: begin
            add_q <= regWdata;
            ua_q <= 1'b0; // RL14
          end
          `TW_REG_IFLAG: begin
            if (!regWdata[`TW_IF_BIT]) begin
              intFlag_q <= 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
      if (regRd && regAddr == `TW_REG_BUF) begin
        bf_q <= 1'b0;
      end
      // Buffer writes: master load, slave load, or collision
      if (wrBuf) begin
        if (isMst && en_q) begin
          if (mBusy) begin
            write_collision_flag_q <= 1'b1; // RL1
          end else begin
            buf_q <= regWdata;
            bf_q <= 1'b1;
            mSr_q <= regWdata; // RL17 RL18
            mRx_q <= 1'b0;
            mSt_q <= M_XFER;
            mPh_q <= 2'd0;
            mBit_q <= 3'd0;
          end
        end else if (sSt_q == S_TX && (sCnt_q != 4'h0 || sInAck_q)) begin
          write_collision_flag_q <= 1'b1; // RL2
        end else begin
          buf_q <= regWdata;
          if (sSt_q == S_TX) begin
            sTx_q <= regWdata;
            bf_q <= 1'b1;
            sSdaLow_q <= ~regWdata[7];
          end
        end
      end
      // Master sequencer, four quarter-bit phases per bit
      if (mGo) begin
        mPh_q <= mPh_q + 2'd1;
        case (mSt_q)
          M_IDLE: begin
            mPh_q <= 2'd0;
            // Start from a held bus becomes a repeated start
            if (sen_q) begin
              mSt_q <= M_START; // RL16 RL20
            end else if (pen_q) begin
              mSt_q <= M_STOP; // RL23
            end else if (rcen_q) begin
              mSt_q <= M_XFER;
              mRx_q <= 1'b1;
              mBit_q <= 3'd0;
            end
          end
          M_START: begin
            case (mPh_q)
              2'd0: mSdaLow_q <= 1'b0;
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSdaLow_q <= 1'b1;
              default: begin
                mSclLow_q <= 1'b1;
                sen_q <= 1'b0;
                intFlag_q <= 1'b1; // RL20
                mSt_q <= M_IDLE;
              end
            endcase
          end
          M_XFER: begin
            case (mPh_q)
              2'd0: mSdaLow_q <= ~mRx_q & ~mSr_q[7]; // RL17
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSr_q <= {mSr_q[6:0], sdaS};
              default: begin
                mSclLow_q <= 1'b1;
                mBit_q <= mBit_q + 3'd1;
                if (mBit_q == 3'd7) begin
                  mSt_q <= M_ACK;
                  if (mRx_q) begin
                    if (bf_q) begin
                      ov_q <= 1'b1; // RL3
                    end else begin
                      buf_q <= mSr_q;
                      bf_q <= 1'b1;
                    end
                  end else begin
                    bf_q <= 1'b0;
                  end
                end
              end
            endcase
          end
          M_ACK: begin
            case (mPh_q)
              2'd0: mSdaLow_q <= mRx_q & ~ackDt_q; // RL18
              2'd1: mSclLow_q <= 1'b0;
              2'd2: begin
                if (!mRx_q) begin
                  ackStat_q <= sdaS; // RL21
                end
              end
              default: begin
                mSclLow_q <= 1'b1;
                intFlag_q <= 1'b1; // RL22
                rcen_q <= 1'b0;
                mSt_q <= M_IDLE;
              end
            endcase
          end
          default: begin
            case (mPh_q)
              2'd0: mSdaLow_q <= 1'b1;
              2'd1: mSclLow_q <= 1'b0;
              2'd2: mSdaLow_q <= 1'b0;
              default: begin
                pen_q <= 1'b0;
                intFlag_q <= 1'b1; // RL23
                mSt_q <= M_IDLE;
              end
            endcase
          end
        endcase
      end
      if (!en_q || !isMst) begin
        mSt_q <= M_IDLE;
        mSdaLow_q <= 1'b0;
        mSclLow_q <= 1'b0;
      end
      // Slave: clock stretch latches low once the line is low
      sSclLow_q <= isSl & (sSt_q != S_IDLE) & ~ckp_q & (sSclLow_q | ~sclS); // RL5
      if (isSl && rise && sSt_q != S_IDLE) begin
        if (sCnt_q != 4'h8) begin
          sSr_q <= newByte; // RL12
          sCnt_q <= sCnt_q + 4'h1;
        end else begin
          sCnt_q <= 4'h0;
          if (sSt_q == S_TX) begin
            if (sdaS) begin
              sSt_q <= S_IDLE;
            end else begin
              sInAck_q <= 1'b1;
            end
          end
        end
      end
      if (byteDone) begin
        case (sSt_q)
          S_ADDR: begin
            if (gcHit) begin
              buf_q <= newByte; // RL13
              bf_q <= 1'b1;
              sAckPend_q <= 1'b1;
              rw_q <= 1'b0;
              sSt_q <= S_RX; // RL15
            end else if (adHit) begin
              buf_q <= newByte;
              bf_q <= ~newByte[0];
              sAckPend_q <= 1'b1;
              rw_q <= newByte[0];
              if (newByte[0]) begin
                sSt_q <= S_TX;
              end else if (is10) begin
                ua_q <= 1'b1; // RL14
                sSt_q <= S_ADDR2;
              end else begin
                sSt_q <= S_RX;
              end
            end else begin
              sSt_q <= S_IDLE;
            end
          end
          S_ADDR2: begin
            if (newByte == add_q) begin
              buf_q <= newByte;
              bf_q <= 1'b1;
              sAckPend_q <= 1'b1;
              ua_q <= 1'b1; // RL14
              sSt_q <= S_RX;
            end else begin
              sSt_q <= S_IDLE;
            end
          end
          S_RX: begin
            if (bf_q) begin
              ov_q <= 1'b1; // RL3
            end else begin
              buf_q <= newByte;
              bf_q <= 1'b1;
              sAckPend_q <= 1'b1;
            end
          end
          default: begin
            bf_q <= 1'b0;
          end
        endcase
      end
      if (isSl && fall) begin
        if (sAckPend_q) begin
          sSdaLow_q <= 1'b1;
          sAckPend_q <= 1'b0;
          sInAck_q <= 1'b1;
        end else if (sInAck_q) begin
          // End of the ninth bit: release data, flag software
          sSdaLow_q <= 1'b0;
          sInAck_q <= 1'b0;
          intFlag_q <= 1'b1; // RL13
          if (sSt_q == S_TX) begin
            ckp_q <= 1'b0; // RL5
          end
        end else if (sSt_q == S_TX && sCnt_q != 4'h0) begin
          sSdaLow_q <= (sCnt_q == 4'h8) ? 1'b0 : ~sTx_q[txIdx]; // RL2
        end
      end
      if (isSl && startDet) begin
        sSt_q <= S_ADDR; // RL12
        sCnt_q <= 4'h0;
        sSdaLow_q <= 1'b0;
        sAckPend_q <= 1'b0;
        sInAck_q <= 1'b0;
      end
      if (isSl && stopDet) begin
        sSt_q <= S_IDLE;
        sSdaLow_q <= 1'b0;
      end
      if (isSl && ssIrq && (startDet || stopDet)) begin
        intFlag_q <= 1'b1; // RL8
      end
      if (!isSl) begin
        sSt_q <= S_IDLE; // RL9
        sSdaLow_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // Pins and read data
  // --------------------------------------------------------------
  // Open drain: outputs stay low, enables pull the wire down
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      pinsOwned <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
      sdaOe <= en_q & (mSdaLow_q | sSdaLow_q); // RL4
      sclOe <= en_q & (mSclLow_q | sSclLow_q); // RL4 RL16
      pinsOwned <= en_q; // RL4
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= `TW_RST_BYTE;
    end else if (regRd) begin
      case (regAddr)
        `TW_REG_CON1: regRdata <= {write_collision_flag_q, ov_q, en_q, ckp_q, mode_q};
        `TW_REG_CON2: regRdata <= {general_call_enable_q, ackStat_q, ackDt_q, 1'b0,
                                   rcen_q, pen_q, 1'b0, sen_q};
        `TW_REG_STAT: regRdata <= {5'h00, rw_q, ua_q, bf_q};
        `TW_REG_BUF: regRdata <= buf_q;
        `TW_REG_ADDR: regRdata <= add_q;
        `TW_REG_IFLAG: regRdata <= {7'h00, intFlag_q};
        default: regRdata <= `TW_RST_BYTE;
      endcase
    end else begin
      regRdata <= `TW_RST_BYTE;
    end
  end
endmodule

/* File: tw_monitor.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the two-wire block
// ----------------------------------------
module tw_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic pinsOwned
);
  logic [7:0] reloadQ;
  logic mstQ;
  logic [7:0] halfQ;
  logic sclOePrevQ;
  // Shadow of reload and mode, and cycles since the clock pin last moved
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reloadQ <= 8'h00;
      mstQ <= 1'b0;
      halfQ <= 8'hff;
      sclOePrevQ <= 1'b0;
    end else begin
      if (regWr && regAddr == 3'h4) reloadQ <= regWdata;
      if (regWr && regAddr == 3'h0) mstQ <= regWdata[3:0] == 4'h8 || regWdata[3:0] == 4'hb;
      sclOePrevQ <= sclOe;
      // Saturates so a long idle gap never wraps into a short one
      if (sclOe != sclOePrevQ) halfQ <= 8'h01;
      else if (halfQ != 8'hff) halfQ <= halfQ + 8'h01;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rd_idle;
    !$past(regRd) |-> regRdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_unmapped;
    $past(regRd) && $past(regAddr) > 3'h5 |-> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read not zero");
  property p_stat_rsvd;
    $past(regRd) && $past(regAddr) == 3'h2 |-> regRdata[7:3] == 5'h00;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
  property p_con2_rsvd;
    $past(regRd) && $past(regAddr) == 3'h1 |-> !regRdata[4] && !regRdata[1];
  endproperty
  a_con2_rsvd: assert property (p_con2_rsvd) else $error("control two spare bits set");
  property p_owned;
    regWr && regAddr == 3'h0 |-> ##2 pinsOwned == $past(regWdata[5], 2);
  endproperty
  a_owned: assert property (p_owned) else $error("pin ownership not following enable");
  property p_released;
    !pinsOwned && !$past(pinsOwned) |-> !sdaOe && !sclOe;
  endproperty
  a_released: assert property (p_released) else $error("pins driven while port off");
  property p_open_drain;
    sdaOut == 1'b0 && sclOut == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_scl_half;
    mstQ && sclOe != sclOePrevQ |-> {2'b00, halfQ} >= (({2'b00, reloadQ} + 10'h001) << 1);
  endproperty
  a_scl_half: assert property (p_scl_half) else $error("clock half period too short");
endmodule
bind tw_serial_port tw_monitor uMon (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .pinsOwned(pinsOwned));

/* File: tw_bus_slave.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Far-side slave: acks its address, takes writes, resends one byte until a NACK
// ----------------------------------------
module tw_bus_slave #(
  parameter [6:0] SLAVE_ADDR = 7'h50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclLine,
  input wire logic sdaLine,
  input wire logic [7:0] txByte,
  output logic sdaPull,
  output logic [7:0] lastByte
);
  logic sclQ, sdaQ, active, inAddr, rdMode, ackPh, nack;
  logic [3:0] bitCnt;
  logic [7:0] sr, txSh;
  // Sampled on the system clock so wire edges never race the model
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {sclQ, sdaQ} <= 2'b11;
      {active, inAddr, rdMode, ackPh, nack, sdaPull} <= 6'h00;
      bitCnt <= 4'h0;
      sr <= 8'h00;
      txSh <= 8'h00;
      lastByte <= 8'h00;
    end else begin
      sclQ <= sclLine;
      sdaQ <= sdaLine;
      if (sclQ && sclLine && sdaQ && !sdaLine) begin
        {active, inAddr, rdMode, ackPh, sdaPull} <= 5'b11000;
        bitCnt <= 4'h0;
      end else if (sclQ && sclLine && !sdaQ && sdaLine) begin
        {active, sdaPull} <= 2'b00;
      end else if (active && !sclQ && sclLine) begin
        if (ackPh) nack <= sdaLine;
        else if (bitCnt < 4'h8) begin
          sr <= {sr[6:0], sdaLine};
          bitCnt <= bitCnt + 4'h1;
        end
      end else if (active && sclQ && !sclLine) begin
        if (ackPh) begin
          {ackPh, inAddr} <= 2'b00;
          bitCnt <= 4'h0;
          // A master NACK ends the read, so the line is let go
          if (rdMode && (inAddr || !nack)) begin
            sdaPull <= !txByte[7];
            txSh <= {txByte[6:0], 1'b0};
          end else begin
            sdaPull <= 1'b0;
            if (rdMode) active <= 1'b0;
          end
        end else if (bitCnt == 4'h8) begin
          ackPh <= 1'b1;
          if (inAddr) begin
            rdMode <= sr[0];
            sdaPull <= sr[7:1] == SLAVE_ADDR;
            active <= sr[7:1] == SLAVE_ADDR;
          end else if (rdMode) sdaPull <= 1'b0;
          else begin
            lastByte <= sr;
            sdaPull <= 1'b1;
          end
        end else if (rdMode && !inAddr) begin
          sdaPull <= !txSh[7];
          txSh <= {txSh[6:0], 1'b0};
        end
      end
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
`include "tw_consts.vh"
module testbench;
  // ----------------------------------------
  // Clock, reset, register port and bus wires
  // ----------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  wire [7:0] regRdata, slvByte;
  wire sdaOe, sclOe, pinsOwned, slvPull;
  // Open-drain lines with pull-ups
  wire sdaLine = ~(sdaOe | slvPull);
  wire sclLine = ~sclOe;
  integer n_fail = 0;
  integer tests_run = 0;
  integer i;
  logic [7:0] rd;
  logic [23:0] modeList = 24'h678b_ef;
  localparam [7:0] TX_BYTE = 8'h3c;
  always #20 clk = ~clk;
  tw_serial_port DUT (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sdaIn(sdaLine), .sdaOut(),
    .sdaOe(sdaOe), .sclIn(sclLine), .sclOut(), .sclOe(sclOe), .pinsOwned(pinsOwned));
  tw_bus_slave #(.SLAVE_ADDR(7'h50)) uSlave (.clk(clk), .reset_n(reset_n), .sclLine(sclLine),
    .sdaLine(sdaLine), .txByte(TX_BYTE), .sdaPull(slvPull), .lastByte(slvByte));
  // ----------------------------------------
  // Register port tasks and compare
  // ----------------------------------------
  task regWrite(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task regRead(input [2:0] a, output [7:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
    end
  endtask
  task check8(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task readCheck(input [2:0] a, input [7:0] m, input [7:0] exp);
    begin
      regRead(a, rd);
      check8(rd & m, exp);
    end
  endtask
  // Polls the flag with a bound, then clears it for the next step
  task waitFlag;
    integer k;
    begin
      rd = 8'h00;
      for (k = 0; k < 1000 && rd[0] !== 1'b1; k = k + 1) regRead(`TW_REG_IFLAG, rd);
      check8({7'h00, rd[0]}, 8'h01);
      regWrite(`TW_REG_IFLAG, 8'h00);
    end
  endtask
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_fail = n_fail + 1;
    summarize;
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    readCheck(`TW_REG_CON1, 8'hff, 8'h00);
    readCheck(`TW_REG_STAT, 8'hff, 8'h00);
    regWrite(3'h7, 8'hff);
    readCheck(3'h6, 8'hff, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      regWrite(`TW_REG_CON1, {4'h2, modeList[23-4*i -: 4]});
      readCheck(`TW_REG_CON1, 8'hff, {4'h2, modeList[23-4*i -: 4]});
    end
    regWrite(`TW_REG_ADDR, 8'(`TW_BRG_400K));
    regWrite(`TW_REG_CON1, 8'h28);
    readCheck(`TW_REG_CON1, 8'hff, 8'h28);
    check8({7'h00, pinsOwned}, 8'h01);
    regWrite(`TW_REG_CON2, 8'h01);
    waitFlag;
    // Second load while the address byte shifts is refused
    regWrite(`TW_REG_BUF, 8'ha0);
    regWrite(`TW_REG_BUF, 8'h55);
    readCheck(`TW_REG_CON1, 8'h80, 8'h80);
    waitFlag;
    readCheck(`TW_REG_CON2, 8'h40, 8'h00);
    regWrite(`TW_REG_CON1, 8'h28);
    readCheck(`TW_REG_CON1, 8'hff, 8'h28);
    regWrite(`TW_REG_ADDR, 8'h03);
    regWrite(`TW_REG_BUF, 8'ha5);
    waitFlag;
    check8(slvByte, 8'ha5);
    // Repeated start into a read, last byte not acknowledged
    regWrite(`TW_REG_CON2, 8'h01);
    waitFlag;
    regWrite(`TW_REG_BUF, 8'ha1);
    waitFlag;
    readCheck(`TW_REG_CON2, 8'h40, 8'h00);
    // Acked bytes keep the far side sending; the third lands on a full buffer
    regWrite(`TW_REG_CON2, 8'h08);
    waitFlag;
    readCheck(`TW_REG_BUF, 8'hff, TX_BYTE);
    regWrite(`TW_REG_CON2, 8'h08);
    waitFlag;
    regWrite(`TW_REG_CON2, 8'h28);
    waitFlag;
    readCheck(`TW_REG_CON1, 8'h40, 8'h40);
    readCheck(`TW_REG_BUF, 8'hff, TX_BYTE);
    regWrite(`TW_REG_CON2, 8'h04);
    waitFlag;
    check8({6'h00, sdaLine, sclLine}, 8'h03);
    // Firmware master code drives the same sequencer
    regWrite(`TW_REG_CON1, 8'h2b);
    // Nobody answers this address
    regWrite(`TW_REG_CON2, 8'h01);
    waitFlag;
    regWrite(`TW_REG_BUF, 8'h42);
    waitFlag;
    readCheck(`TW_REG_CON2, 8'h40, 8'h40);
    regWrite(`TW_REG_CON2, 8'h04);
    waitFlag;
    regWrite(`TW_REG_CON1, 8'h00);
    readCheck(`TW_REG_CON1, 8'hff, 8'h00);
    check8({7'h00, pinsOwned}, 8'h00);
    summarize;
  end
endmodule
